/* hdl/pms_cfg.svh */
// Summary of operation
// - Normal mode keeps core and every ungated peripheral clocked and working.
// - Core-halt request bit enters idle; peripherals stay clocked; any interrupt resumes.
// - Suspend halts core and digital peripherals and switches internal oscillators off.
// - Sleep powers down most nets, keeps retention nets, pins, RAM and registers.
// - Suspend or sleep wakes on alarm, oscillator failure, pin match, comparator rise.
// - After any wake the core resumes execution; no reset is issued.
// - Reset selects the low-power oscillator divided by eight.
// - Divider offers divide by 1, 2, 4, 8, 16, 32, 64 or 128.
// - Clocks of unused digital peripherals are gated off.
// - From idle, execution restarts two to three system clocks after a wake.
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define PMS_OFF_PCON 12'h000
`define PMS_OFF_PUCF 12'h004
`define PMS_OFF_CLKSEL 12'h008
`define PMS_OFF_PGATE 12'h00C
`define PMS_OFF_STATUS 12'h010
`define PMS_OFF_IRQST 12'h014
`define PMS_OFF_IRQMSK 12'h018
`define PMS_BIT_IDLE 0
`define PMS_BIT_SUSPEND 0
`define PMS_BIT_SLEEP 1
`define PMS_SRC_LPOSC 2'h0
`define PMS_SRC_HFOSC 2'h1
`define PMS_SRC_EXT 2'h2
`define PMS_RST_DIV 3'h3
`define PMS_IDLE_WAKE_CYC 2
`define PMS_OSC_WAKE_CYC 2
`endif

/* hdl/pms_pkg.sv */
package pms_pkg;
  typedef enum logic [2:0] {
    PMS_NORMAL,
    PMS_IDLE,
    PMS_SUSPEND,
    PMS_SLEEP,
    PMS_RESUME
  } pms_state_t;
endpackage : pms_pkg

/* hdl/pms_power_ctrl.sv */
`timescale 1ns/1ns
`include "pms_cfg.svh"
module pms_power_ctrl import pms_pkg::*; #(
  parameter int NUM_PERIPH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic anyIrq,
  input wire logic alarmWake,
  input wire logic oscFailWake,
  input wire logic pinMatchWake,
  input wire logic cmp0Out,
  output logic coreRun,
  output logic periphClkEn,
  output logic [NUM_PERIPH-1:0] periphClkGate,
  output logic fastOscEn,
  output logic lowPowerOscEn,
  output logic [1:0] clkSrcSel,
  output logic [2:0] clkDivSel,
  output logic powerNetsOn,
  output logic retainHold,
  output logic irq
);
  pms_state_t state_r;
  logic [1:0] cnt_r;
  logic pconIdle_r;
  logic [1:0] pucf_r;
  logic [1:0] clkSrc_r;
  logic [2:0] clkDiv_r;
  logic [NUM_PERIPH-1:0] gate_r;
  logic [3:0] irqSt_r;
  logic [3:0] irqMsk_r;
  logic [2:0] aSync_r, fSync_r, mSync_r, cSync_r, iSync_r;
  logic cmpPrev_r;
  logic aLvl, fLvl, mLvl, cLvl, iLvl;
  logic deepWake, cmpRise;
  logic wrEn, rdEn;
  logic [31:0] rdNxt;

  function automatic logic syncLvl(input logic [2:0] s);
    syncLvl = s[2] & s[1];
  endfunction : syncLvl

  // Three stages per asynchronous pin; the level is high only while the last two stages are both high.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aSync_r <= 3'h0;
      fSync_r <= 3'h0;
      mSync_r <= 3'h0;
      cSync_r <= 3'h0;
      iSync_r <= 3'h0;
    end else begin
      aSync_r <= {aSync_r[1:0], alarmWake};
      fSync_r <= {fSync_r[1:0], oscFailWake};
      mSync_r <= {mSync_r[1:0], pinMatchWake};
      cSync_r <= {cSync_r[1:0], cmp0Out};
      iSync_r <= {iSync_r[1:0], anyIrq};
    end
  end

  assign aLvl = syncLvl(aSync_r);
  assign fLvl = syncLvl(fSync_r);
  assign mLvl = syncLvl(mSync_r);
  assign cLvl = syncLvl(cSync_r);
  assign iLvl = syncLvl(iSync_r);
  assign cmpRise = cLvl & ~cmpPrev_r;
  assign deepWake = aLvl | fLvl | mLvl | cmpRise;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmpPrev_r <= 1'b0;
    end else if ((cSync_r[2] == cSync_r[1])) begin
      cmpPrev_r <= cLvl;
    end
  end

  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;

  // Mode state machine; wake always resumes execution rather than resetting.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= PMS_NORMAL;
      cnt_r <= 2'h0;
    end else begin
      case (state_r)
        PMS_NORMAL: begin
          if (pucf_r[`PMS_BIT_SLEEP]) begin
            state_r <= PMS_SLEEP;
          end else if (pucf_r[`PMS_BIT_SUSPEND]) begin
            state_r <= PMS_SUSPEND;
          end else if (pconIdle_r) begin
            state_r <= PMS_IDLE;
          end
        end
        PMS_IDLE: begin
          if (iLvl) begin
            state_r <= PMS_RESUME;
            cnt_r <= 2'(`PMS_IDLE_WAKE_CYC - 1);
          end
        end
        PMS_SUSPEND, PMS_SLEEP: begin
          if (deepWake) begin
            state_r <= PMS_RESUME;
            cnt_r <= 2'(`PMS_OSC_WAKE_CYC - 1);
          end
        end
        PMS_RESUME: begin
          if (cnt_r == 2'h0) begin
            state_r <= PMS_NORMAL;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        default: begin
          state_r <= PMS_NORMAL;
        end
      endcase
    end
  end

  // Request bits clear on wake so the core fetches only after the mode is left.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pconIdle_r <= 1'b0;
      pucf_r <= 2'h0;
    end else if ((state_r == PMS_IDLE && iLvl) || ((state_r == PMS_SUSPEND || state_r == PMS_SLEEP) && deepWake)) begin
      pconIdle_r <= 1'b0;
      pucf_r <= 2'h0;
    end else if (wrEn && state_r == PMS_NORMAL) begin
      if (paddr == `PMS_OFF_PCON) begin
        pconIdle_r <= pwdata[`PMS_BIT_IDLE];
      end
      if (paddr == `PMS_OFF_PUCF) begin
        pucf_r <= pwdata[1:0];
      end
    end
  end

  // Suspend is entered with any clock source selected; the source is not checked before entry.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clkSrc_r <= `PMS_SRC_LPOSC;
      clkDiv_r <= `PMS_RST_DIV;
      gate_r <= '0;
    end else if (wrEn) begin
      if (paddr == `PMS_OFF_CLKSEL) begin
        clkSrc_r <= pwdata[1:0];
        clkDiv_r <= pwdata[6:4];
      end
      if (paddr == `PMS_OFF_PGATE) begin
        gate_r <= pwdata[NUM_PERIPH-1:0];
      end
    end
  end

  // Sticky wake events; a new event beats a write-one clear in the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqSt_r <= 4'h0;
      irqMsk_r <= 4'h0;
    end else begin
      irqSt_r <= (irqSt_r & ~((wrEn && paddr == `PMS_OFF_IRQST) ? pwdata[3:0] : 4'h0))
        | {cmpRise, mLvl, fLvl, aLvl};
      if (wrEn && paddr == `PMS_OFF_IRQMSK) begin
        irqMsk_r <= pwdata[3:0];
      end
    end
  end

  always_comb begin
    rdNxt = 32'h0;
    case (paddr)
      `PMS_OFF_PCON: rdNxt = {31'h0, pconIdle_r};
      `PMS_OFF_PUCF: rdNxt = {30'h0, pucf_r};
      `PMS_OFF_CLKSEL: rdNxt = {25'h0, clkDiv_r, 2'h0, clkSrc_r};
      `PMS_OFF_PGATE: rdNxt = 32'(gate_r);
      `PMS_OFF_STATUS: rdNxt = {29'h0, state_r};
      `PMS_OFF_IRQST: rdNxt = {28'h0, irqSt_r};
      `PMS_OFF_IRQMSK: rdNxt = {28'h0, irqMsk_r};
      default: rdNxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= rdNxt;
      pslverr <= psel & ~penable & (paddr > `PMS_OFF_IRQMSK || paddr[1:0] != 2'h0);
      if (rdEn) begin
        prdata <= rdNxt;
      end
    end
  end

  // Outputs registered from the current state_r and setting registers so they follow them by one edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      coreRun <= 1'b1;
      periphClkEn <= 1'b1;
      periphClkGate <= '0;
      fastOscEn <= 1'b0;
      lowPowerOscEn <= 1'b1;
      clkSrcSel <= `PMS_SRC_LPOSC;
      clkDivSel <= `PMS_RST_DIV;
      powerNetsOn <= 1'b1;
      retainHold <= 1'b0;
      irq <= 1'b0;
    end else begin
      coreRun <= (state_r == PMS_NORMAL);
      periphClkEn <= ~(state_r == PMS_SUSPEND || state_r == PMS_SLEEP);
      periphClkGate <= (state_r == PMS_SUSPEND || state_r == PMS_SLEEP) ? '0 : ~gate_r;
      fastOscEn <= (clkSrc_r == `PMS_SRC_HFOSC) && state_r != PMS_SUSPEND && state_r != PMS_SLEEP;
      lowPowerOscEn <= (clkSrc_r == `PMS_SRC_LPOSC) && state_r != PMS_SUSPEND && state_r != PMS_SLEEP;
      clkSrcSel <= clkSrc_r;
      clkDivSel <= clkDiv_r;
      powerNetsOn <= (state_r != PMS_SLEEP);
      retainHold <= (state_r == PMS_SLEEP);
      irq <= |(irqSt_r & irqMsk_r);
    end
  end
endmodule : pms_power_ctrl

/* tb/pms_power_ctrl_props.sv */
`timescale 1ns/1ns
module pms_power_ctrl_props #(parameter int NUM_PERIPH = 8) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic anyIrq,
  input wire logic alarmWake,
  input wire logic coreRun,
  input wire logic periphClkEn,
  input wire logic [NUM_PERIPH-1:0] periphClkGate,
  input wire logic fastOscEn,
  input wire logic lowPowerOscEn,
  input wire logic [1:0] clkSrcSel,
  input wire logic [2:0] clkDivSel,
  input wire logic powerNetsOn,
  input wire logic retainHold
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rstVal; $fell(rst) |-> clkDivSel == 3'h3 && clkSrcSel == 2'h0 && lowPowerOscEn; endproperty
  a_rstVal: assert property (p_rstVal) else $error("reset clock setting wrong");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_susp; !periphClkEn |-> !coreRun && !fastOscEn && !lowPowerOscEn && !(|periphClkGate); endproperty
  a_susp: assert property (p_susp) else $error("clocks left running while halted");
  property p_sleep; !powerNetsOn |-> retainHold && !periphClkEn; endproperty
  a_sleep: assert property (p_sleep) else $error("retention missing");
  property p_wake; $rose(alarmWake) && !periphClkEn |-> ##[3:10] coreRun; endproperty
  a_wake: assert property (p_wake) else $error("no resume after alarm");
  property p_idle; $rose(anyIrq) && !coreRun && periphClkEn |-> ##[3:8] coreRun; endproperty
  a_idle: assert property (p_idle) else $error("idle resume late");
  // An external source may be selected, so neither oscillator is then required.
  property p_resume; $rose(coreRun) |-> periphClkEn && (fastOscEn || lowPowerOscEn || clkSrcSel == 2'h2); endproperty
  a_resume: assert property (p_resume) else $error("core ran before clocks returned");
  // The pins follow the register one edge late, so two quiet cycles are needed before stability is owed.
  property p_div; !(psel && penable && pwrite) ##1 !(psel && penable && pwrite) |=> $stable(clkDivSel) && $stable(clkSrcSel); endproperty
  a_div: assert property (p_div) else $error("clock setting moved without a write");
endmodule : pms_power_ctrl_props
bind pms_power_ctrl pms_power_ctrl_props #(.NUM_PERIPH(NUM_PERIPH)) i_props (.clk_sys, .rst, .psel, .penable,
  .pwrite, .pready, .anyIrq, .alarmWake, .coreRun, .periphClkEn, .periphClkGate, .fastOscEn, .lowPowerOscEn,
  .clkSrcSel, .clkDivSel, .powerNetsOn, .retainHold);

/* tb/pms_power_ctrl_tb_top.sv */
`timescale 1ns/1ns
module pms_power_ctrl_tb_top;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} pms_row_t;
  logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, anyIrq = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, coreRun, periphClkEn, fastOscEn, lowPowerOscEn, powerNetsOn, retainHold, irq;
  logic [3:0] wk = 4'h0;
  logic [7:0] periphClkGate;
  logic [1:0] clkSrcSel;
  logic [2:0] clkDivSel;
  int n_errors = 0;
  int checked = 0;
  pms_row_t rows [4] = '{'{12'h008, 32'h51, 32'h51, 1'h0}, '{12'h00C, 32'hA5, 32'hA5, 1'h0},
    '{12'h018, 32'hE, 32'hE, 1'h0}, '{12'h020, 32'hFFFF, 32'h0, 1'h1}};
  always #4 clk_sys = ~clk_sys;
  pms_power_ctrl #(.NUM_PERIPH(8)) i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .anyIrq, .alarmWake(wk[0]), .oscFailWake(wk[1]), .pinMatchWake(wk[2]), .cmp0Out(wk[3]),
    .coreRun, .periphClkEn, .periphClkGate, .fastOscEn, .lowPowerOscEn, .clkSrcSel, .clkDivSel, .powerNetsOn,
    .retainHold, .irq);
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    // Ready, data and error are taken at the rising edge that samples ready high, as the request still stands.
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      n_errors++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Waiting on the clock enable too lets one task cover both halt and resume.
  task automatic waitFor(logic sel, logic v);
    int n;
    n = 0;
    while ((sel ? periphClkEn : coreRun) !== v) begin
      @(negedge clk_sys);
      n++;
      if (n > 30) begin
        n_errors++;
        stop_test();
      end
    end
  endtask : waitFor
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    @(negedge clk_sys);
    chk("reset", {coreRun, periphClkEn, lowPowerOscEn, fastOscEn, clkSrcSel, clkDivSel, powerNetsOn}, 32'h387);
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d);
      chk("wr err", er, rows[i].e);
      apb(1'h0, rows[i].a, 32'h0);
      chk("rd data", rd, rows[i].r);
      chk("rd err", er, rows[i].e);
    end
    chk("gate", periphClkGate, 32'h5A);
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, 12'h008, 32'(i * 16 + 1));
      // The setting reaches the output pins one edge after the register takes it.
      repeat (2) @(negedge clk_sys);
      chk("divider", {clkSrcSel, clkDivSel}, 32'(8 + i));
    end
    $display("register test done");
    apb(1'h1, 12'h000, 32'h1);
    waitFor(1'h0, 1'h0);
    chk("idle periph", {periphClkEn, powerNetsOn}, 32'h3);
    @(posedge clk_sys);
    anyIrq <= 1'h1;
    waitFor(1'h0, 1'h1);
    anyIrq <= 1'h0;
    chk("no reset", {clkSrcSel, clkDivSel}, 32'hF);
    $display("idle test done");
    for (int i = 0; i < 4; i++) begin
      // The fast oscillator is already selected; the last pass wakes on the comparator output, cmp0Out.
      apb(1'h1, 12'h004, 32'(i % 2 + 1));
      waitFor(1'h1, 1'h0);
      chk("halted", {coreRun, fastOscEn, lowPowerOscEn, periphClkGate}, 32'h0);
      chk("nets", {powerNetsOn, retainHold}, (i % 2) ? 32'h1 : 32'h2);
      @(posedge clk_sys);
      wk <= 4'h1 << i;
      waitFor(1'h0, 1'h1);
      chk("resumed", {periphClkEn, fastOscEn, irq}, 32'(6 + (i != 0)));
      @(posedge clk_sys);
      wk <= 4'h0;
      apb(1'h0, 12'h004, 32'h0);
      chk("request", rd, 32'h0);
      apb(1'h0, 12'h014, 32'h0);
      chk("status", rd, 32'h1 << i);
      apb(1'h1, 12'h014, 32'hF);
      repeat (2) @(negedge clk_sys);
      chk("irq clear", irq, 32'h0);
    end
    $display("wake test done");
    @(posedge clk_sys);
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    @(negedge clk_sys);
    chk("mid reset", {coreRun, periphClkEn, lowPowerOscEn, fastOscEn, clkSrcSel, clkDivSel, powerNetsOn}, 32'h387);
    $display("mid reset test done");
    stop_test();
  end
endmodule : pms_power_ctrl_tb_top
